/* File: rtl/mcgc_clock_gating.v */
/*
 * Per-unit clock gating, capability registers and gated-access fault
 * checking, reached by software over APB.
 * Assumes pclk at 50 MHz, presetn asynchronous active low, and that the
 * system decoder presents each peripheral access as a one-hot select.
 */
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`include "mcgc_regs.vh"

// Overview of operation
// - A set gate bit clocks its unit; clear leaves it unclocked.
// - Access to an unclocked peripheral is answered with a bus fault.
// - All gate bits read zero after reset.
// - Run, sleep and deep-sleep gate registers apply in their modes.
// - Sleep and deep-sleep gate registers apply only with auto gating selected.
// - Speed field 9:8 picks 500K, 250K or 125K samples per second.
// - Effective sample speed never exceeds the reported maximum.
// - Pin presence bits 5:0 read one for the PWM pins.
// - Pin presence bits 21:16 read one; bits 23:22 read zero.
// - Pin presence bits 8, 7 and 6 report comparator pins.
// - Port presence reads one in bits 4:0, zero above.
module mcgc_clock_gating (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    power_mode,
    periph_sel,
    periph_fault,
    pwm_clk_en,
    adc_clk_en,
    wdt_clk_en,
    converter_sample_speed,
    irq
);
    input  wire        pclk;
    input  wire        presetn;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [11:0] paddr;
    input  wire [31:0] pwdata;
    output reg  [31:0] prdata;
    output reg         pready;
    output reg         pslverr;
    input  wire [1:0]  power_mode;
    input  wire [2:0]  periph_sel;
    output reg         periph_fault;
    output reg         pwm_clk_en;
    output reg         adc_clk_en;
    output reg         wdt_clk_en;
    output reg  [1:0]  converter_sample_speed;
    output reg         irq;

    ////////////////////////////////////////////////////////////////////////
    reg  [31:0] run_clock_gates_reg;
    reg  [31:0] sleep_clock_gates_reg;
    reg  [31:0] deep_sleep_clock_gates_reg;
    reg         auto_gating_select_reg;
    reg  [1:0]  int_status_reg;
    reg  [1:0]  int_mask_reg;
    reg  [31:0] gates_in_force;
    reg  [31:0] rd_next;
    reg         hit_next;
    wire        access;
    wire        wr;
    wire [2:0]  gate_vec;
    wire        fault_next;
    wire [1:0]  spd_req;
    wire        clamp_evt;
    wire [1:0]  event_vec;
    wire        first_access;
    wire        wr_run;
    wire        wr_sleep;
    wire        wr_deep;
    wire        wr_cfg;
    wire        wr_mask;
    wire        wr_sts;

    // Number of sticky interrupt sources held in the status register.
    localparam N_EVENTS = 2;

    assign access = psel & penable & pready;
    assign wr     = access & pwrite;

    // The first access cycle is where the answer is prepared; the slave
    // always answers in the cycle after it.
    assign first_access = psel & penable & ~pready;

    // True when the transfer addresses the given register offset.
    function is_reg;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            is_reg = (addr == ofs);
        end
    endfunction

    // Clamp a requested speed code to the reported maximum.
    function [1:0] clamp_speed;
        input [1:0] code;
        begin
            if (code > `MCGC_MAX_SPEED_CODE) begin
                clamp_speed = `MCGC_MAX_SPEED_CODE;
            end else begin
                clamp_speed = code;
            end
        end
    endfunction

    // One write strobe per register keeps the decode in a single place, so
    // a new register cannot be written by a stray offset match.
    assign wr_run   = wr & is_reg(paddr, `MCGC_OFS_RUN_GATES);
    assign wr_sleep = wr & is_reg(paddr, `MCGC_OFS_SLEEP_GATES);
    assign wr_deep  = wr & is_reg(paddr, `MCGC_OFS_DEEP_GATES);
    assign wr_cfg   = wr & is_reg(paddr, `MCGC_OFS_RUN_CONFIG);
    assign wr_mask  = wr & is_reg(paddr, `MCGC_OFS_INT_MASK);
    assign wr_sts   = wr & is_reg(paddr, `MCGC_OFS_INT_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Sleep registers only take over when auto gating is selected; without
    // it the run settings stay in force so sleeping never loses a clock.
    always @* begin
        gates_in_force = run_clock_gates_reg;
        if (auto_gating_select_reg) begin
            case (power_mode)
                `MCGC_MODE_SLEEP: begin
                    gates_in_force = sleep_clock_gates_reg;
                end
                `MCGC_MODE_DEEP: begin
                    gates_in_force = deep_sleep_clock_gates_reg;
                end
                default: begin
                    gates_in_force = run_clock_gates_reg;
                end
            endcase
        end
    end

    // Ordered to match the one-hot select: bit 0 PWM, bit 1 ADC, bit 2 WDT.
    // A mismatch here would fault the wrong unit silently.
    assign gate_vec = {gates_in_force[`MCGC_BIT_WDT],
                       gates_in_force[`MCGC_BIT_ADC],
                       gates_in_force[`MCGC_BIT_PWM]};
    // Any attempt on a unit whose gate is off in the current mode faults,
    // whichever register set happens to be in force.
    assign fault_next = |(periph_sel & ~gate_vec);
    assign spd_req = gates_in_force[`MCGC_SPD_HI:`MCGC_SPD_LO];
    // Software is told when a run or sleep gate write asked for more speed than
    // the converter offers; the stored code is kept, only the output is limited.
    assign clamp_evt = (wr_run | wr_sleep) &&
                       (pwdata[`MCGC_SPD_HI:`MCGC_SPD_LO] >
                        `MCGC_MAX_SPEED_CODE);
    assign event_vec = {clamp_evt, fault_next};

    ////////////////////////////////////////////////////////////////////////
    // Read mux. Unmapped offsets clear hit_next, which turns into an error
    // response; mapped read-only words simply ignore writes.
    always @* begin
        hit_next = 1'b1;
        rd_next  = 32'h0000_0000;
        case (paddr)
            `MCGC_OFS_PIN_PRESENCE:  rd_next = `MCGC_PIN_PRESENCE_VAL;
            `MCGC_OFS_PORT_PRESENCE: rd_next = `MCGC_PORT_PRESENCE_VAL;
            `MCGC_OFS_MAX_SPEED: begin
                rd_next[`MCGC_SPD_HI:`MCGC_SPD_LO] = `MCGC_MAX_SPEED_CODE;
            end
            `MCGC_OFS_RUN_GATES:   rd_next = run_clock_gates_reg;
            `MCGC_OFS_SLEEP_GATES: rd_next = sleep_clock_gates_reg;
            `MCGC_OFS_DEEP_GATES:  rd_next = deep_sleep_clock_gates_reg;
            `MCGC_OFS_RUN_CONFIG: begin
                rd_next[`MCGC_BIT_ACG] = auto_gating_select_reg;
            end
            `MCGC_OFS_POWER_MODE: rd_next = {30'h0000_0000, power_mode};
            `MCGC_OFS_INT_STATUS: rd_next = {30'h0000_0000, int_status_reg};
            `MCGC_OFS_INT_MASK:   rd_next = {30'h0000_0000, int_mask_reg};
            default: begin
                hit_next = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // One wait state: pready rises in the second access cycle, so every
    // transfer takes setup plus two access cycles.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= first_access;
            pslverr <= first_access & ~hit_next;
            prdata  <= (first_access & ~pwrite) ? rd_next : 32'h0000_0000;
        end
    end

    // Gate registers keep only their writable bits, so reserved and
    // read-only positions always read back as zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_clock_gates_reg <= `MCGC_GATE_RESET;
        end else if (wr_run) begin
            run_clock_gates_reg <= pwdata & `MCGC_GATE_MASK;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_clock_gates_reg <= `MCGC_GATE_RESET;
        end else if (wr_sleep) begin
            sleep_clock_gates_reg <= pwdata & `MCGC_GATE_MASK;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep_clock_gates_reg <= `MCGC_GATE_RESET;
        end else if (wr_deep) begin
            deep_sleep_clock_gates_reg <= pwdata & `MCGC_GATE_MASK;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_gating_select_reg <= 1'b0;
        end else if (wr_cfg) begin
            auto_gating_select_reg <= pwdata[`MCGC_BIT_ACG];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_reg <= 2'h0;
        end else if (wr_mask) begin
            int_mask_reg <= pwdata[1:0];
        end
    end

    // Status bits: a fresh event beats a write-one-to-clear, so an event
    // that lands with the clear is never lost to software.
    genvar gi;
    generate
        for (gi = 0; gi < N_EVENTS; gi = gi + 1) begin : g_sts
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    int_status_reg[gi] <= 1'b0;
                end else if (event_vec[gi]) begin
                    int_status_reg[gi] <= 1'b1;
                end else if (wr_sts && pwdata[gi]) begin
                    int_status_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Enables are registered so that a mode change or a register write can
    // never glitch a unit's clock in mid-cycle; the cost is one cycle lag.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_clk_en             <= 1'b0;
            adc_clk_en             <= 1'b0;
            wdt_clk_en             <= 1'b0;
            converter_sample_speed <= 2'h0;
            periph_fault           <= 1'b0;
        end else begin
            pwm_clk_en             <= gates_in_force[`MCGC_BIT_PWM];
            adc_clk_en             <= gates_in_force[`MCGC_BIT_ADC];
            wdt_clk_en             <= gates_in_force[`MCGC_BIT_WDT];
            converter_sample_speed <= clamp_speed(spd_req);
            periph_fault           <= fault_next;
        end
    end

    // The interrupt line follows status and mask one cycle late, which
    // keeps it free of decode glitches for the interrupt controller.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status_reg & int_mask_reg);
        end
    end
endmodule

/* File: rtl/mcgc_regs.vh */
/*
 * Register map, field positions and reset values of the clock gating
 * and capability block.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef MCGC_REGS_VH
`define MCGC_REGS_VH

`define MCGC_OFS_PIN_PRESENCE  12'h018
`define MCGC_OFS_PORT_PRESENCE 12'h01C
`define MCGC_OFS_RUN_GATES     12'h100
`define MCGC_OFS_SLEEP_GATES   12'h110
`define MCGC_OFS_DEEP_GATES    12'h120
`define MCGC_OFS_RUN_CONFIG    12'h060
`define MCGC_OFS_POWER_MODE    12'h064
`define MCGC_OFS_INT_STATUS    12'h068
`define MCGC_OFS_INT_MASK      12'h06C
`define MCGC_OFS_MAX_SPEED     12'h010

`define MCGC_BIT_WDT           3
`define MCGC_BIT_ADC           16
`define MCGC_BIT_PWM           20
`define MCGC_SPD_LO            8
`define MCGC_SPD_HI            9
`define MCGC_BIT_ACG           27

`define MCGC_GATE_MASK         32'h0011_0308
`define MCGC_GATE_RESET        32'h0000_0000
`define MCGC_PIN_PRESENCE_VAL  32'hBF3F_01FF
`define MCGC_PORT_PRESENCE_VAL 32'h0000_001F
`define MCGC_MAX_SPEED_CODE    2'h2

`define MCGC_MODE_RUN          2'h0
`define MCGC_MODE_SLEEP        2'h1
`define MCGC_MODE_DEEP         2'h2

`define MCGC_INT_FAULT         0
`define MCGC_INT_CLAMP         1

`endif

/* File: testbench/mcgc_checker.sv */
/* Port checker for the clock gating block.
   Assumes one pclk domain and presetn asynchronous, active low. */
`timescale 1ns/100ps
module mcgc_checker (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [2:0]  periph_sel,
    input logic        periph_fault,
    input logic        pwm_clk_en,
    input logic        adc_clk_en,
    input logic        wdt_clk_en,
    input logic [1:0]  converter_sample_speed
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [2:0] en = {wdt_clk_en, adc_clk_en, pwm_clk_en};
    ////////////////////////////////////////////////////////////////////
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_wait; $rose(psel && penable) |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr alone");
    property p_rdz; !pready |-> prdata == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("prdata not idle");
    property p_flt; |(periph_sel & ~en) |=> periph_fault; endproperty
    a_flt: assert property (p_flt) else $error("fault missed");
    property p_nflt;
        periph_sel != 3'h0 && (periph_sel & ~en) == 3'h0 |=> !periph_fault;
    endproperty
    a_nflt: assert property (p_nflt) else $error("false fault");
    property p_clamp; converter_sample_speed != 2'h3; endproperty
    a_clamp: assert property (p_clamp) else $error("speed over max");
    property p_rst; $rose(presetn) |-> en == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("gate on at reset");
    property p_pins;
        pready && !pwrite && paddr == 12'h018 |-> prdata == 32'hBF3F01FF;
    endproperty
    a_pins: assert property (p_pins) else $error("pin word");
    property p_ports;
        pready && !pwrite && paddr == 12'h01C |-> prdata == 32'h0000001F;
    endproperty
    a_ports: assert property (p_ports) else $error("port word");
    c_err: cover property (pready && pslverr);
    c_flt: cover property (periph_fault);
    c_spd: cover property (converter_sample_speed == 2'h2);
endmodule
bind mcgc_clock_gating mcgc_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_sel(periph_sel), .periph_fault(periph_fault),
    .pwm_clk_en(pwm_clk_en), .adc_clk_en(adc_clk_en),
    .wdt_clk_en(wdt_clk_en), .converter_sample_speed(converter_sample_speed));

/* File: testbench/tb_module_clock_gating_and_capability.sv */
/* Self-checking bench for the clock gating block.
   Assumes the checker binds itself to the design. */
`timescale 1ns/100ps
module tb_module_clock_gating_and_capability;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [1:0]  power_mode, converter_sample_speed;
    logic [2:0]  periph_sel;
    logic        pready, pslverr, periph_fault, irq;
    logic        pwm_clk_en, adc_clk_en, wdt_clk_en;
    logic [32:0] eq[$];
    int          errors, n_checks;

    mcgc_clock_gating DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_mode(power_mode), .periph_sel(periph_sel),
        .periph_fault(periph_fault), .pwm_clk_en(pwm_clk_en),
        .adc_clk_en(adc_clk_en), .wdt_clk_en(wdt_clk_en),
        .converter_sample_speed(converter_sample_speed), .irq(irq));
    ////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task cmp_bus(logic [32:0] e, logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] bus exp %h got %h", e, g);
        end
    endtask
    task cmp_pin(string n, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // The expected word is {pslverr, prdata}; writes expect zero data.
    task apb(bit w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
        eq.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge pclk)
        if (pready === 1'b1)
            cmp_bus(eq.size() ? eq.pop_front() : 33'h0, {pslverr, prdata});
    task gates(logic [4:0] e);
        repeat (2) @(posedge pclk);
        #1 cmp_pin("gates", {27'h0, e}, {27'h0, pwm_clk_en, adc_clk_en,
            wdt_clk_en, converter_sample_speed});
    endtask
    task flt(logic [2:0] s, logic e);
        @(posedge pclk);
        periph_sel <= s;
        @(posedge pclk);
        periph_sel <= 3'h0;
        #1 cmp_pin("fault", {31'h0, e}, {31'h0, periph_fault});
    endtask
    // Both status bits are masked in, so irq must drop only on clearing.
    task irq_clr(logic [4:0] e);
        gates(e);
        cmp_pin("irq", 32'h1, {31'h0, irq});
        apb(1, 12'h068, 32'h3, 33'h0);
        repeat (2) @(posedge pclk);
        #1 cmp_pin("irq", 32'h0, {31'h0, irq});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        v = $urandom(46971);
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        power_mode = 2'h0;
        periph_sel = 3'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        gates(5'h00);
        apb(0, 12'h100, 0, 33'h0);
        apb(0, 12'h018, 0, {1'b0, 32'hBF3F01FF});
        apb(1, 12'h01C, 32'hFFFFFFFF, 33'h0);
        apb(0, 12'h01C, 0, 33'h1F);
        apb(0, 12'h200, 0, 33'h1_0000_0000);
        apb(1, 12'h06C, 32'h3, 33'h0);
        for (int i = 0; i < 3; i++) flt(3'h1 << i, 1'b1);
        irq_clr(5'h00);
        for (int c = 0; c < 4; c++) begin
            v = ($urandom & 32'hFFFFFCFF) | (32'(c) << 8);
            apb(1, 12'h100, v, 33'h0);
            apb(0, 12'h100, 0, {1'b0, v & 32'h00110308});
            gates({v[20], v[16], v[3], c == 3 ? 2'h2 : 2'(c)});
        end
        irq_clr({v[20], v[16], v[3], 2'h2});
        apb(1, 12'h100, 32'h00110208, 33'h0);
        for (int i = 0; i < 3; i++) flt(3'h1 << i, 1'b0);
        apb(1, 12'h110, 32'h00000108, 33'h0);
        apb(1, 12'h120, 32'h00100000, 33'h0);
        @(posedge pclk) power_mode <= 2'h1;
        gates(5'h1E);
        apb(1, 12'h060, 32'h08000000, 33'h0);
        gates(5'h05);
        flt(3'h1, 1'b1);
        @(posedge pclk) power_mode <= 2'h2;
        gates(5'h10);
        cmp_pin("deep", 32'h4, {29'h0, pwm_clk_en, adc_clk_en, wdt_clk_en});
        @(posedge pclk) power_mode <= 2'h0;
        gates(5'h1E);
        end_sim();
    end
    initial begin
        repeat (3000) @(posedge pclk);
        errors++;
        end_sim();
    end
endmodule
